// *** rtl/sehr_defines.svh ***
// constants of the serial eeprom status, id page and pause logic
// assumes a 10 MHz system clock and a host-driven serial clock
// Behaviour
// - id page read uses the array read sequence, only with page select set
// - id page byte is chosen by the six low address bits, shifted out
// - id page address increments per byte while select stays low
// - status shifting starts right after the last command bit
// - status read is accepted at any time, also during a write cycle
// - busy status read gives full register, or ff on the legacy revision
// - once busy reads zero the next status read is fully correct
// - while paused output floats and serial input is ignored
// - after reset the write enable latch is clear
// - writes without the write enable latch set are rejected
// - an instruction is accepted only after select has gone low
// - a completed write clears the write enable latch
// - write cycle starts only on select rising at a byte boundary
// - array access during a write cycle is ignored
// - unknown opcode is ignored and output stays floating
// - page select latch clears after each completed id page read or array write
// - write-in-progress flag is high while the write cycle runs
// - during a write cycle all but the status read are ignored
`ifndef SEHR_DEFINES_SVH
`define SEHR_DEFINES_SVH

`define SEHR_OP_STATUS_WRITE     8'h01
`define SEHR_OP_ARRAY_WRITE      8'h02
`define SEHR_OP_ARRAY_READ       8'h03
`define SEHR_OP_WRITE_LATCH_CLR  8'h04
`define SEHR_OP_READ_STATUS      8'h05
`define SEHR_OP_WRITE_LATCH_SET  8'h06

`define SEHR_ST_WPEN   7
`define SEHR_ST_IPSEL  6
`define SEHR_ST_LOCK   4
`define SEHR_ST_BP_HI  3
`define SEHR_ST_BP_LO  2
`define SEHR_ST_WEL    1
`define SEHR_ST_BUSY   0
`define SEHR_ST_LEGACY_BUSY 8'hff

`define SEHR_PAGE_BYTES      64
`define SEHR_PAGE_BITS       512

`define SEHR_CLK_PERIOD_NS   100
`define SEHR_WRITE_CYCLE_NS  5000000
`define SEHR_WRITE_CYCLES    (`SEHR_WRITE_CYCLE_NS / `SEHR_CLK_PERIOD_NS)

`endif

// *** rtl/sehr_pkg.sv ***
// types of the serial eeprom status, id page and pause logic
// assumes nothing of its surroundings
package sehr_pkg;

   typedef enum logic [2:0] {
      st_op        = 3'h0,
      st_addr_hi   = 3'h1,
      st_addr_lo   = 3'h3,
      st_stream    = 3'h2,
      st_wr_data   = 3'h6,
      st_status_in = 3'h7,
      st_ignore    = 3'h5
   } sehr_state_t;

   typedef enum logic {
      md_status = 1'b0,
      md_page   = 1'b1
   } sehr_mode_t;

endpackage

// *** rtl/sehr_byte_if.sv ***
// byte-level carrier between the serial shifter and the command logic
// assumes both ends run on the serial clock
`timescale 1ns/1ps
interface sehr_byte_if;
   logic [7:0] rx_byte;
   logic       rx_done;
   logic       first;
   logic       freeze;
   logic [2:0] bit_cnt;
   logic [7:0] tx_byte;

   modport shifter (
      output rx_byte,
      output rx_done,
      output first,
      output freeze,
      output bit_cnt,
      input  tx_byte
   );

   modport decoder (
      input  rx_byte,
      input  rx_done,
      input  first,
      input  freeze,
      input  bit_cnt,
      output tx_byte
   );
endinterface

// *** rtl/sehr_shift.sv ***
// serial shifter: bit counter, input shift, output bit on falling edge
// assumes frame_rst_n low while select is high, hold_n from the pin
`timescale 1ns/1ps
module sehr_shift (
   input  wire logic  sck,
   input  wire logic  frame_rst_n,
   input  wire logic  si,
   input  wire logic  hold_n,
   output logic       so,
   sehr_byte_if.shifter bus
);

   logic [2:0] cnt_q;
   logic [6:0] sh_q;
   logic       first_q;
   logic       so_q;

   assign bus.freeze  = ~hold_n;
   assign bus.rx_done = (cnt_q == 3'h7) & ~bus.freeze;
   assign bus.rx_byte = {sh_q, si};
   assign bus.first   = first_q;
   assign bus.bit_cnt = cnt_q;
   assign so          = so_q;

   ////////////////////////////////////////////////////////////////////////
   // input side, rising edge
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_q   <= 3'h0;
         sh_q    <= 7'h00;
         first_q <= 1'b1;
      end else if (!bus.freeze) begin
         cnt_q   <= cnt_q + 3'h1;
         sh_q    <= {sh_q[5:0], si};
         first_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output side, falling edge, msb first
   always_ff @(negedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_q <= 1'b0;
      end else if (!bus.freeze) begin
         so_q <= bus.tx_byte[~cnt_q];
      end
   end

endmodule // sehr_shift

// *** rtl/sehr_top.sv ***
// serial eeprom front end: command decode, status, id page, write cycle
// assumes serial pins straight from the pads, host keeps select high
// for at least four system clock periods between frames
`timescale 1ns/1ps
`include "sehr_defines.svh"
module sehr_top #(
   parameter int                          WRITE_CYCLE_CYCLES =
      `SEHR_WRITE_CYCLES,
   parameter bit                          LEGACY_REV         = 1'b0,
   parameter logic [`SEHR_PAGE_BITS-1:0]  ID_PAGE_INIT       = '0
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic hold_n,
   output logic      so_o,
   output logic      so_oe
);

   sehr_byte_if bus ();

   logic                frame_rst_n;
   logic [7:0]          page [`SEHR_PAGE_BYTES];
   // serial clock domain
   sehr_pkg::sehr_state_t state_q;
   sehr_pkg::sehr_mode_t  mode_q;
   logic [5:0]          addr_q;
   logic [7:0]          tx_q;
   logic                oe_q;
   logic                arm_q;
   logic [7:0]          op_q;
   logic [7:0]          wr_stat_q;
   logic                page_rd_q;
   logic [7:0]          stat_m_q;
   logic [7:0]          stat_s_q;
   logic                rdy_m_q;
   logic                rdy_s_q;
   logic [7:0]          status_view;
   logic                busy_s;
   logic                accept;
   // system clock domain
   logic                cs_m_q;
   logic                cs_s_q;
   logic                cs_d_q;
   logic                cs_rise;
   logic                ready_q;
   logic                wel_q;
   logic                ipsel_q;
   logic                wpen_q;
   logic                lock_q;
   logic [1:0]          bp_q;
   logic                busy_q;
   logic                lag_q;
   logic [31:0]         wcnt_q;
   logic [7:0]          pend_op_q;
   logic [7:0]          pend_stat_q;
   logic [7:0]          status_q;
   logic                start_wr;

   assign frame_rst_n = resetn & ~cs_n;

   sehr_shift u_shift (
      .sck         (sck),
      .frame_rst_n (frame_rst_n),
      .si          (si),
      .hold_n      (hold_n),
      .so          (so_o),
      .bus         (bus)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `SEHR_PAGE_BYTES; gi++) begin : g_page
         assign page[gi] = ID_PAGE_INIT[gi*8 +: 8];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // status and ready into the serial clock domain
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         stat_m_q <= 8'h00;
         stat_s_q <= 8'h00;
         rdy_m_q  <= 1'b0;
         rdy_s_q  <= 1'b0;
      end else begin
         stat_m_q <= status_q;
         stat_s_q <= stat_m_q;
         rdy_m_q  <= ready_q;
         rdy_s_q  <= rdy_m_q;
      end
   end

   assign busy_s      = stat_s_q[`SEHR_ST_BUSY];
   assign status_view = (LEGACY_REV && busy_s) ?
                        `SEHR_ST_LEGACY_BUSY : stat_s_q;
   assign accept      = rdy_s_q & (~busy_s |
                        (bus.rx_byte == `SEHR_OP_READ_STATUS));
   assign bus.tx_byte = tx_q;
   assign so_oe       = oe_q & ~bus.first & ~cs_n & hold_n;

   ////////////////////////////////////////////////////////////////////////
   // command state, output byte
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         state_q <= sehr_pkg::st_op;
         mode_q  <= sehr_pkg::md_status;
         tx_q    <= 8'h00;
         oe_q    <= 1'b0;
      end else if (!bus.freeze) begin
         if (bus.first) begin
            state_q <= sehr_pkg::st_op;
            oe_q    <= 1'b0;
         end
         if (bus.rx_done) begin
            case (state_q)
               sehr_pkg::st_op: begin
                  if (!accept) begin
                     state_q <= sehr_pkg::st_ignore;
                  end else begin
                     case (bus.rx_byte)
                        `SEHR_OP_READ_STATUS: begin
                           state_q <= sehr_pkg::st_stream;
                           mode_q  <= sehr_pkg::md_status;
                           tx_q    <= status_view;
                           oe_q    <= 1'b1;
                        end
                        `SEHR_OP_ARRAY_READ: begin
                           state_q <= sehr_pkg::st_addr_hi;
                        end
                        `SEHR_OP_ARRAY_WRITE: begin
                           state_q <= stat_s_q[`SEHR_ST_WEL] ?
                                      sehr_pkg::st_addr_hi :
                                      sehr_pkg::st_ignore;
                        end
                        `SEHR_OP_STATUS_WRITE: begin
                           state_q <= stat_s_q[`SEHR_ST_WEL] ?
                                      sehr_pkg::st_status_in :
                                      sehr_pkg::st_ignore;
                        end
                        default: begin
                           state_q <= sehr_pkg::st_ignore;
                        end
                     endcase
                  end
               end
               sehr_pkg::st_addr_hi: begin
                  state_q <= sehr_pkg::st_addr_lo;
               end
               sehr_pkg::st_addr_lo: begin
                  if (op_q == `SEHR_OP_ARRAY_WRITE) begin
                     state_q <= sehr_pkg::st_wr_data;
                  end else if (stat_s_q[`SEHR_ST_IPSEL]) begin
                     state_q <= sehr_pkg::st_stream;
                     mode_q  <= sehr_pkg::md_page;
                     tx_q    <= page[bus.rx_byte[5:0]];
                     oe_q    <= 1'b1;
                  end else begin
                     state_q <= sehr_pkg::st_ignore;
                  end
               end
               sehr_pkg::st_stream: begin
                  tx_q <= (mode_q == sehr_pkg::md_page) ?
                          page[addr_q] : status_view;
               end
               sehr_pkg::st_wr_data,
               sehr_pkg::st_status_in,
               sehr_pkg::st_ignore: begin
                  state_q <= state_q;
               end
               default: begin
                  state_q <= sehr_pkg::st_ignore;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // id page address
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         addr_q <= 6'h00;
      end else if (!bus.freeze && bus.rx_done) begin
         if (state_q == sehr_pkg::st_addr_lo) begin
            addr_q <= bus.rx_byte[5:0] + 6'h01;
         end else if (state_q == sehr_pkg::st_stream &&
                      mode_q == sehr_pkg::md_page) begin
            addr_q <= addr_q + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame outcome seen by the system clock domain at select rise
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         arm_q     <= 1'b0;
         op_q      <= 8'h00;
         wr_stat_q <= 8'h00;
         page_rd_q <= 1'b0;
      end else if (!bus.freeze) begin
         arm_q <= 1'b0;
         if (bus.first) begin
            op_q      <= 8'h00;
            page_rd_q <= 1'b0;
         end
         if (bus.rx_done) begin
            case (state_q)
               sehr_pkg::st_op: begin
                  if (accept) begin
                     op_q  <= bus.rx_byte;
                     arm_q <= (bus.rx_byte == `SEHR_OP_WRITE_LATCH_SET) ||
                              (bus.rx_byte == `SEHR_OP_WRITE_LATCH_CLR);
                  end
               end
               sehr_pkg::st_wr_data: begin
                  arm_q <= 1'b1;
               end
               sehr_pkg::st_status_in: begin
                  arm_q     <= 1'b1;
                  wr_stat_q <= bus.rx_byte;
               end
               sehr_pkg::st_addr_lo: begin
                  page_rd_q <= (op_q == `SEHR_OP_ARRAY_READ) &&
                               stat_s_q[`SEHR_ST_IPSEL];
               end
               default: begin
                  arm_q <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // select into the system clock domain
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         cs_d_q <= 1'b1;
      end else begin
         cs_m_q <= cs_n;
         cs_s_q <= cs_m_q;
         cs_d_q <= cs_s_q;
      end
   end

   assign cs_rise  = cs_s_q & ~cs_d_q;
   assign start_wr = cs_rise & arm_q & ~busy_q &
                     ((op_q == `SEHR_OP_ARRAY_WRITE) ||
                      (op_q == `SEHR_OP_STATUS_WRITE));

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ready_q <= 1'b0;
      end else if (!cs_s_q) begin
         ready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write enable latch
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wel_q <= 1'b0;
      end else if (busy_q && wcnt_q == 32'h0) begin
         wel_q <= 1'b0;
      end else if (cs_rise && arm_q && !busy_q) begin
         if (op_q == `SEHR_OP_WRITE_LATCH_SET) begin
            wel_q <= 1'b1;
         end else if (op_q == `SEHR_OP_WRITE_LATCH_CLR) begin
            wel_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write cycle timer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy_q      <= 1'b0;
         lag_q       <= 1'b0;
         wcnt_q      <= 32'h0;
         pend_op_q   <= 8'h00;
         pend_stat_q <= 8'h00;
      end else begin
         lag_q <= busy_q;
         if (start_wr) begin
            busy_q      <= 1'b1;
            wcnt_q      <= 32'(WRITE_CYCLE_CYCLES - 1);
            pend_op_q   <= op_q;
            pend_stat_q <= wr_stat_q;
         end else if (busy_q) begin
            if (wcnt_q == 32'h0) begin
               busy_q <= 1'b0;
            end else begin
               wcnt_q <= wcnt_q - 32'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status bits committed at the end of the write cycle, page select also cleared at select rise after an id page read
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ipsel_q <= 1'b0;
         wpen_q  <= 1'b0;
         lock_q  <= 1'b0;
         bp_q    <= 2'h0;
      end else if (busy_q && wcnt_q == 32'h0) begin
         if (pend_op_q == `SEHR_OP_STATUS_WRITE) begin
            wpen_q <= pend_stat_q[`SEHR_ST_WPEN];
            bp_q   <= pend_stat_q[`SEHR_ST_BP_HI:`SEHR_ST_BP_LO];
            if (!(pend_stat_q[`SEHR_ST_IPSEL] &&
                  pend_stat_q[`SEHR_ST_LOCK])) begin
               ipsel_q <= pend_stat_q[`SEHR_ST_IPSEL];
               lock_q  <= lock_q | pend_stat_q[`SEHR_ST_LOCK];
            end
         end else begin
            ipsel_q <= 1'b0;
         end
      end else if (cs_rise && page_rd_q) begin
         ipsel_q <= 1'b0;
      end
   end

   assign status_q = {wpen_q, ipsel_q, 1'b0, lock_q, bp_q, wel_q,
                      busy_q | lag_q};

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_status_load: assert property (@(posedge sck) disable iff (!resetn || cs_n)
      bus.rx_done && state_q == sehr_pkg::st_op && rdy_s_q &&
      bus.rx_byte == `SEHR_OP_READ_STATUS
      |=> oe_q && tx_q == $past(status_view))
      else $error("status not loaded after command");
   a_bad_op_float: assert property (@(posedge sck) disable iff (!resetn || cs_n)
      bus.rx_done && state_q == sehr_pkg::st_op && !bus.first &&
      bus.rx_byte > `SEHR_OP_WRITE_LATCH_SET |=> !oe_q ##1 !oe_q)
      else $error("output enabled on unknown opcode");
   a_busy_ignore: assert property (@(posedge sck) disable iff (!resetn || cs_n)
      bus.rx_done && state_q == sehr_pkg::st_op && busy_s &&
      bus.rx_byte != `SEHR_OP_READ_STATUS
      |=> state_q == sehr_pkg::st_ignore)
      else $error("command taken during write cycle");
   a_page_step: assert property (@(posedge sck) disable iff (!resetn || cs_n)
      bus.rx_done && state_q == sehr_pkg::st_stream &&
      mode_q == sehr_pkg::md_page
      |=> addr_q == $past(addr_q) + 6'h01 && tx_q == page[$past(addr_q)])
      else $error("id page address did not step");
   a_hold_freeze: assert property (@(posedge sck) disable iff (!resetn || cs_n)
      bus.freeze |=> $stable(state_q) && $stable(tx_q) && $stable(addr_q))
      else $error("state moved while paused");
   a_hold_float: assert property (@(posedge sck) disable iff (!resetn)
      !hold_n |-> !so_oe)
      else $error("output driven while paused");
   a_wel_cause: assert property (@(posedge clock) disable iff (!resetn)
      $rose(wel_q) |-> $past(cs_rise && arm_q &&
      op_q == `SEHR_OP_WRITE_LATCH_SET))
      else $error("write latch set without command");
   a_write_start: assert property (@(posedge clock) disable iff (!resetn)
      $rose(busy_q) |-> $past(cs_rise) && $past(wel_q))
      else $error("write cycle started without select rise");
   a_write_done: assert property (@(posedge clock) disable iff (!resetn)
      $fell(busy_q) |-> !wel_q && status_q[`SEHR_ST_BUSY]
      ##1 !status_q[`SEHR_ST_BUSY])
      else $error("write end did not clear latch in order");
   a_busy_flag: assert property (@(posedge clock) disable iff (!resetn)
      busy_q |-> status_q[`SEHR_ST_BUSY])
      else $error("busy flag low during write cycle");

endmodule // sehr_top

// *** verification/sehr_host_model.sv ***
// host spi controller model: select, serial clock, data, pause
// assumes mode 0 with the serial clock idling low between frames
`timescale 1ns/1ps
module sehr_host_model (
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   output logic      hold_n,
   input  wire logic so_o,
   input  wire logic so_oe
);
   initial begin
      cs_n   = 1'b1;
      sck    = 1'b0;
      si     = 1'b0;
      hold_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // one frame, msb first, optional pause with one clock pulse before hold_at
   task automatic frame(input int nb, input logic [63:0] tx, input int hold_at,
                        output logic [63:0] rx, output logic oe_seen,
                        output logic hold_oe);
      rx      = '0;
      oe_seen = 1'b0;
      hold_oe = 1'b0;
      cs_n    = 1'b0;
      #300;
      for (int i = 8*nb-1; i >= 0; i--) begin
         si = tx[i];
         if (i == hold_at) begin
            #20 hold_n = 1'b0;
            #20 si = ~si;
            #20 hold_oe = so_oe;
            sck = 1'b1;
            #40 sck = 1'b0;
            hold_oe = hold_oe | so_oe;
            #20 hold_n = 1'b1;
            si = tx[i];
         end
         #80 rx = {rx[62:0], so_oe ? so_o : 1'bz};
         oe_seen = oe_seen | so_oe;
         sck = 1'b1;
         #80 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
      si = ~si;
      #500;
   endtask
endmodule // sehr_host_model

// *** verification/testbench.sv ***
// self-checking bench of the serial eeprom front end
// assumes the host model and the design files are compiled first
`timescale 1ns/1ps
module testbench;
   localparam int WCYC = 200;
   logic        clock, resetn, cs_n, sck, si, hold_n, so_o, so_oe;
   logic [63:0] rx;
   logic        oe, hoe;
   logic [7:0]  s;
   int          n_fail, compares;
   function automatic logic [511:0] page_val();
      logic [511:0] v;
      for (int k = 0; k < 64; k++) v[8*k +: 8] = 8'(k) ^ 8'h5a;
      return v;
   endfunction
   localparam logic [511:0] PAGE = page_val();
   sehr_top #(.WRITE_CYCLE_CYCLES(WCYC), .LEGACY_REV(1'b0),
      .ID_PAGE_INIT(PAGE)) u_dut (.clock(clock), .resetn(resetn),
      .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_o(so_o),
      .so_oe(so_oe));
   sehr_host_model u_host (.cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));
   always #50 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic e, input logic g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t: flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic cmd(input int nb, input logic [63:0] tx);
      u_host.frame(nb, tx, -1, rx, oe, hoe);
   endtask
   task automatic status();
      cmd(2, 64'h0500);
      s = rx[7:0];
   endtask
   task automatic poll();
      status();
      for (int i = 0; i < 40 && s[0] !== 1'b0; i++) begin
         status();
      end
      chk1(1'b0, s[0]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_refused();
      status();
      chk8(8'h00, s);
      cmd(1, 64'h0a);
      chk1(1'b0, oe);
      cmd(4, 64'h02000055);
      status();
      chk8(8'h00, s);
      $display("test refused done");
   endtask
   task automatic t_hold();
      cmd(1, 64'h06);
      u_host.frame(2, 64'h0500, 1, rx, oe, hoe);
      chk8(8'h02, rx[7:0]);
      chk1(1'b0, hoe);
      cmd(1, 64'h04);
      status();
      chk8(8'h00, s);
      $display("test hold done");
   endtask
   task automatic t_status_write();
      cmd(1, 64'h06);
      cmd(2, 64'h0140);
      status();
      chk8(8'h03, s);
      poll();
      status();
      chk8(8'h40, s);
      $display("test status write done");
   endtask
   task automatic t_id_page();
      cmd(5, 64'h03003e0000);
      chk8(PAGE[8*62 +: 8], rx[15:8]);
      chk8(PAGE[8*63 +: 8], rx[7:0]);
      status();
      chk8(8'h00, s);
      cmd(4, 64'h03000500);
      chk1(1'b0, oe);
      $display("test id page done");
   endtask
   task automatic t_busy();
      cmd(1, 64'h06);
      cmd(2, 64'h0140);
      poll();
      cmd(1, 64'h06);
      cmd(4, 64'h02001255);
      cmd(1, 64'h04);
      cmd(5, 64'h03003e0000);
      chk1(1'b0, oe);
      status();
      chk8(8'h43, s);
      poll();
      status();
      chk8(8'h00, s);
      $display("test busy done");
   endtask
   task automatic t_reset();
      cmd(1, 64'h06);
      status();
      chk8(8'h02, s);
      @(posedge clock);
      #10 resetn = 1'b0;
      repeat (2) @(posedge clock);
      #10 resetn = 1'b1;
      status();
      chk8(8'h00, s);
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clock    = 1'b0;
      resetn   = 1'b0;
      n_fail   = 0;
      compares = 0;
      repeat (4) @(posedge clock);
      #10 resetn = 1'b1;
      t_refused();
      t_hold();
      t_status_write();
      t_id_page();
      t_busy();
      t_reset();
      end_of_test();
   end
   initial begin
      #3000000;
      n_fail++;
      $display("ERROR t=%0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // testbench
